// *** hdl/fec_codec.sv ***
// 4B/5B code-group encoder, scrambler, NRZI and MLT-3 stages, and decoder
`timescale 1ns/100ps

module fec_codec (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Transmit nibbles from the MAC
	input wire logic tx_valid,
	input wire fec_pkg::fec_nib_t tx_nib,
	output logic tx_ready,
	// Configuration
	input wire logic scr_bypass,
	// Transmit line side
	output logic line_bit_strobe,
	output logic line_pos,
	output logic line_neg,
	// Receive code-groups from the line side
	input wire logic rx_sym_valid,
	input wire logic [4:0] rx_sym,
	// Receive nibbles to the MAC
	output logic rx_strobe,
	output logic rx_dv,
	output logic rx_er,
	output logic [3:0] rxd
);
	import fec_pkg::*;

	// ----------------------------------------------------------------
	// Code tables
	// ----------------------------------------------------------------
	function automatic logic [4:0] enc5(input logic [3:0] n);
		logic [4:0] c;
		c = SYM_HALT;
		unique case (n)
			4'h0: c = 5'h1e;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0a;
			4'h5: c = 5'h0b;
			4'h6: c = 5'h0e;
			4'h7: c = 5'h0f;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'ha: c = 5'h16;
			4'hb: c = 5'h17;
			4'hc: c = 5'h1a;
			4'hd: c = 5'h1b;
			4'he: c = 5'h1c;
			4'hf: c = 5'h1d;
		endcase
		return c;
	endfunction

	// Returns {is_data, nibble}; anything not a data code gives is_data 0
	function automatic logic [4:0] dec5(input logic [4:0] c);
		logic [4:0] r;
		r = {1'b0, NIB_ZERO};
		for (int i = 0; i < 16; i++) begin
			if (enc5(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Two-entry buffer between MAC and encoder
	// ----------------------------------------------------------------
	fec_nib_t buf_mem [2];
	logic buf_wr, buf_rd;
	logic [1:0] buf_cnt;
	wire logic buf_push = tx_valid && tx_ready;
	wire logic buf_valid = buf_cnt != 2'h0;
	wire fec_nib_t buf_head = buf_mem[buf_rd];
	logic buf_pop;
	// Ready drops when full, so the MAC waits instead of losing a nibble
	assign tx_ready = buf_cnt != 2'h2;

	// Buffer pointers and count
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_wr <= 1'b0;
			buf_rd <= 1'b0;
			buf_cnt <= 2'h0;
		end else begin
			buf_wr <= buf_wr ^ buf_push;
			buf_rd <= buf_rd ^ buf_pop;
			buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// Buffer storage
	always_ff @(posedge clk) begin
		if (buf_push) begin
			buf_mem[buf_wr] <= tx_nib;
		end
	end

	// ----------------------------------------------------------------
	// Bit timing: one line bit every CLKS_PER_BIT clocks
	// ----------------------------------------------------------------
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_BIT - 1);
	logic [DIV_W-1:0] div_cnt;
	logic [2:0] bit_cnt;
	wire logic bit_tick = div_cnt == DIV_LAST;
	wire logic sym_load = bit_tick && (bit_cnt == LAST_BIT);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= '0;
			bit_cnt <= LAST_BIT;
		end else begin
			div_cnt <= bit_tick ? '0 : div_cnt + DIV_W'(1);
			if (bit_tick) begin
				bit_cnt <= (bit_cnt == LAST_BIT) ? 3'h0 : bit_cnt + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit code-group encoder and injection
	// ----------------------------------------------------------------
	fec_tx_st_t tx_st, next_tx_st;
	logic [4:0] next_sym;
	wire logic head_en = buf_valid && buf_head.en;
	wire logic head_lpi = buf_valid && !buf_head.en && buf_head.er &&
		(buf_head.data == NIB_LPI);
	// Frame sequencing, one decision per symbol period
	always_comb begin
		next_tx_st = tx_st;
		next_sym = SYM_IDLE;
		buf_pop = 1'b0;
		unique case (tx_st)
			FEC_TX_IDLE, FEC_TX_ESD2: begin
				buf_pop = buf_valid;
				next_tx_st = FEC_TX_IDLE;
				if (head_en) begin
					next_sym = SYM_SSD1;
					next_tx_st = FEC_TX_SSD1;
				end else if (head_lpi) begin
					next_sym = SYM_LPI;
				end else begin
					next_sym = SYM_IDLE;
				end
			end
			FEC_TX_SSD1: begin
				buf_pop = head_en;
				next_sym = SYM_SSD2;
				next_tx_st = FEC_TX_SSD2;
			end
			FEC_TX_SSD2, FEC_TX_DATA: begin
				if (head_en) begin
					// Data mapping; halt when MAC flags error
					buf_pop = 1'b1;
					next_sym = buf_head.er ? SYM_HALT : enc5(buf_head.data);
					next_tx_st = FEC_TX_DATA;
				end else begin
					// Enable dropped or underrun: first end delimiter
					next_sym = SYM_ESD1;
					next_tx_st = FEC_TX_ESD1;
				end
			end
			FEC_TX_ESD1: begin
				next_sym = SYM_ESD2;
				next_tx_st = FEC_TX_ESD2;
			end
			default: next_tx_st = FEC_TX_IDLE;
		endcase
		if (!sym_load) begin
			next_tx_st = tx_st;
			buf_pop = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Serializer, scrambler, NRZI and MLT-3
	// ----------------------------------------------------------------
	logic [4:0] shift;
	logic [SCR_W-1:0] scr;
	logic nrzi;
	logic [1:0] mlt_phase;
	wire logic nrz_bit = shift[4];
	wire logic scr_fb = scr[SCR_W-1] ^ scr[SCR_TAP];
	// LFSR output XORed onto serial data; bypass skips it
	wire logic scr_bit = scr_bypass ? nrz_bit : (nrz_bit ^ scr_fb);
	// NRZI toggles on a one, feeding the three-level stage
	wire logic next_nrzi = nrzi ^ scr_bit;
	wire logic [1:0] next_mlt_phase = mlt_phase + {1'b0, next_nrzi ^ nrzi};

	// Encoder state and serial shift, MSB of the code-group first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_st <= FEC_TX_IDLE;
			shift <= SYM_IDLE;
		end else begin
			tx_st <= next_tx_st;
			if (sym_load) begin
				shift <= next_sym;
			end else if (bit_tick) begin
				shift <= {shift[3:0], 1'b0};
			end
		end
	end

	// Line bit stages, updated once per line bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scr <= SCR_SEED;
			nrzi <= 1'b0;
			mlt_phase <= 2'h0;
			line_pos <= 1'b0;
			line_neg <= 1'b0;
			line_bit_strobe <= 1'b0;
		end else begin
			line_bit_strobe <= bit_tick;
			if (bit_tick) begin
				scr <= {scr[SCR_W-2:0], scr_fb};
				nrzi <= next_nrzi;
				mlt_phase <= next_mlt_phase;
				// Phase 1 is +1, phase 3 is -1, even phases are zero
				line_pos <= next_mlt_phase == 2'h1;
				line_neg <= next_mlt_phase == 2'h3;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive decoder and framing check
	// ----------------------------------------------------------------
	fec_rx_st_t rx_st, next_rx_st;
	logic next_dv, next_er;
	logic [3:0] next_rxd;
	wire logic [4:0] rx_dec = dec5(rx_sym);
	wire logic rx_is_data = rx_dec[4];
	// Receive framing, one decision per code-group
	always_comb begin
		next_rx_st = rx_st;
		next_dv = 1'b0;
		next_er = 1'b0;
		next_rxd = NIB_ZERO;
		unique case (rx_st)
			FEC_RX_IDLE: begin
				if (rx_sym == SYM_SSD1) begin
					next_rx_st = FEC_RX_SSD2;
				end else if (rx_sym == SYM_LPI) begin
					// Low-power idle reported with error, no valid
					next_er = 1'b1;
					next_rxd = NIB_LPI;
				end else if (rx_sym != SYM_IDLE) begin
					next_er = 1'b1;
				end
			end
			FEC_RX_SSD2: begin
				if (rx_sym == SYM_SSD2) begin
					// K completes the start, shown as preamble
					next_dv = 1'b1;
					next_rxd = NIB_SSD;
					next_rx_st = FEC_RX_DATA;
				end else begin
					next_er = 1'b1;
					next_rx_st = FEC_RX_IDLE;
				end
			end
			FEC_RX_DATA: begin
				next_dv = 1'b1;
				if (rx_is_data) begin
					next_rxd = rx_dec[3:0];
				end else if (rx_sym == SYM_ESD1) begin
					next_dv = 1'b0;
					next_rx_st = FEC_RX_ESD2;
				end else if (rx_sym == SYM_IDLE) begin
					// Idle inside a frame ends it with error
					next_er = 1'b1;
					next_rx_st = FEC_RX_IDLE;
				end else begin
					// Halt; invalid or control inside data
					next_er = 1'b1;
				end
			end
			FEC_RX_ESD2: begin
				// R closes the frame; anything else is an error
				next_er = rx_sym != SYM_ESD2;
				next_rx_st = FEC_RX_IDLE;
			end
		endcase
	end

	// Receive outputs registered; rx_strobe follows rx_sym_valid every clock, dv, er and rxd update only on a code-group
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_st <= FEC_RX_IDLE;
			rx_strobe <= 1'b0;
			rx_dv <= 1'b0;
			rx_er <= 1'b0;
			rxd <= NIB_ZERO;
		end else begin
			rx_strobe <= rx_sym_valid;
			if (rx_sym_valid) begin
				rx_st <= next_rx_st;
				rx_dv <= next_dv;
				rx_er <= next_er;
				rxd <= next_rxd;
			end
		end
	end
endmodule

// *** include/fec_pkg.sv ***
// Shared constants and carrier types for the 4B/5B symbol codec
package fec_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int LINE_BIT_PS = 8000;
	localparam int CLKS_PER_BIT = (LINE_BIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DIV_W = 2;
	localparam int SYM_BITS = 5;
	localparam logic [2:0] LAST_BIT = 3'h4;
	// ----------------------------------------------------------------
	// Control code-groups
	// ----------------------------------------------------------------
	localparam logic [4:0] SYM_IDLE = 5'h1f;
	localparam logic [4:0] SYM_SSD1 = 5'h18;
	localparam logic [4:0] SYM_SSD2 = 5'h11;
	localparam logic [4:0] SYM_ESD1 = 5'h0d;
	localparam logic [4:0] SYM_ESD2 = 5'h07;
	localparam logic [4:0] SYM_HALT = 5'h04;
	localparam logic [4:0] SYM_LPI = 5'h00;
	// ----------------------------------------------------------------
	// Nibbles that control code-groups stand for
	// ----------------------------------------------------------------
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_SSD = 4'h5;
	localparam logic [3:0] NIB_LPI = 4'h1;
	// ----------------------------------------------------------------
	// Scrambler: x^11 + x^9 + 1
	// ----------------------------------------------------------------
	localparam int SCR_W = 11;
	localparam int SCR_TAP = 8;
	localparam logic [10:0] SCR_SEED = 11'h7ff;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] data;
	} fec_nib_t;
	typedef enum logic [2:0] {
		FEC_TX_IDLE = 3'h0,
		FEC_TX_SSD1 = 3'h1,
		FEC_TX_SSD2 = 3'h3,
		FEC_TX_DATA = 3'h2,
		FEC_TX_ESD1 = 3'h6,
		FEC_TX_ESD2 = 3'h7
	} fec_tx_st_t;
	typedef enum logic [1:0] {
		FEC_RX_IDLE = 2'h0,
		FEC_RX_SSD2 = 2'h1,
		FEC_RX_DATA = 2'h3,
		FEC_RX_ESD2 = 2'h2
	} fec_rx_st_t;
endpackage

// *** dv/fec_mac_model.sv ***
// Nibble-side transmit model standing in for the MAC
`timescale 1ns/100ps
module fec_mac_model (
	// Clock
	input wire logic clk,
	// Transmit handshake
	input wire logic tx_ready,
	output logic tx_valid,
	output fec_pkg::fec_nib_t tx_nib
);
	import fec_pkg::*;
	int stalls = 0;
	// Quiet bus at time zero
	initial begin
		tx_valid = 1'b0;
		tx_nib = '0;
	end
	task automatic send(input fec_nib_t nib);
		tx_valid = 1'b1;
		tx_nib = nib;
		while (!tx_ready) begin
			stalls++;
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask
	// Released data inverted so stale values never look valid
	task automatic idle(input int n);
		tx_valid = 1'b0;
		tx_nib = ~tx_nib;
		repeat (n) @(posedge clk);
		#1;
	endtask
endmodule

// *** dv/fec_codec_checker.sv ***
// Port checker for the symbol codec
`timescale 1ns/100ps
module fec_codec_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Transmit side
	input wire logic tx_valid,
	input wire fec_pkg::fec_nib_t tx_nib,
	input wire logic tx_ready,
	input wire logic scr_bypass,
	input wire logic line_bit_strobe,
	input wire logic line_pos,
	input wire logic line_neg,
	// Receive side
	input wire logic rx_sym_valid,
	input wire logic [4:0] rx_sym,
	input wire logic rx_strobe,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [3:0] rxd
);
	import fec_pkg::*;
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Codes that never stand for a nibble
	wire bad = rx_sym inside {5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};
	property p_lvl; !(line_pos && line_neg); endproperty
	a_lvl: assert property (p_lvl) else $error("both levels");
	// Three-level output must pass through zero
	property p_step;
		line_bit_strobe |-> !($past(line_pos) && line_neg) && !($past(line_neg) && line_pos);
	endproperty
	a_step: assert property (p_step) else $error("level jump");
	property p_hold; !line_bit_strobe |-> $stable({line_pos, line_neg}); endproperty
	a_hold: assert property (p_hold) else $error("level moved");
	property p_rate; line_bit_strobe |=> !line_bit_strobe ##1 line_bit_strobe; endproperty
	a_rate: assert property (p_rate) else $error("bit rate");
	property p_rxkeep; !rx_strobe |-> $stable({rx_dv, rx_er, rxd}); endproperty
	a_rxkeep: assert property (p_rxkeep) else $error("rx moved");
	property p_bad; rx_sym_valid && bad |=> rx_strobe && rx_er; endproperty
	a_bad: assert property (p_bad) else $error("no error");
	property p_halt; rx_sym_valid && rx_sym == SYM_HALT |=> rx_er; endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_full; $fell(tx_ready) |-> $past(tx_valid); endproperty
	a_full: assert property (p_full) else $error("full");
	c_err: cover property (rx_strobe && rx_er);
	c_full: cover property (tx_valid && !tx_ready);
	c_neg: cover property (line_bit_strobe && line_neg);
endmodule
bind fec_codec fec_codec_checker u_fec_codec_checker (.clk(clk), .reset_n(reset_n),
	.tx_valid(tx_valid), .tx_nib(tx_nib), .tx_ready(tx_ready), .scr_bypass(scr_bypass),
	.line_bit_strobe(line_bit_strobe), .line_pos(line_pos), .line_neg(line_neg),
	.rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .rx_strobe(rx_strobe), .rx_dv(rx_dv),
	.rx_er(rx_er), .rxd(rxd));

// *** dv/test_fec_codec.sv ***
// Self-checking bench for the symbol codec
`timescale 1ns/100ps
module test_fec_codec;
	import fec_pkg::*;
	logic clk, reset_n, scr_bypass, rx_sym_valid;
	logic [4:0] rx_sym;
	logic tx_valid, tx_ready, line_bit_strobe, line_pos, line_neg, rx_strobe, rx_dv, rx_er;
	logic [3:0] rxd;
	fec_nib_t tx_nib;
	int num_errors = 0;
	int check_count = 0;
	int bits = -1;
	int zrun = 0;
	int zmax = 0;
	logic [1:0] lvl = 2'h0;
	logic [9:0] sh = 10'h000;
	logic [4:0] syms [$];
	logic [4:0] code [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic [4:0] junk [14] = '{SYM_SSD1, SYM_SSD2, SYM_ESD2, SYM_HALT, SYM_LPI, 5'h01,
		5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};
	always #2 clk = ~clk;
	fec_codec u_fec_codec (.clk(clk), .reset_n(reset_n), .tx_valid(tx_valid),
		.tx_nib(tx_nib), .tx_ready(tx_ready), .scr_bypass(scr_bypass),
		.line_bit_strobe(line_bit_strobe), .line_pos(line_pos), .line_neg(line_neg),
		.rx_sym_valid(rx_sym_valid), .rx_sym(rx_sym), .rx_strobe(rx_strobe), .rx_dv(rx_dv),
		.rx_er(rx_er), .rxd(rxd));
	fec_mac_model u_fec_mac_model (.clk(clk), .tx_ready(tx_ready), .tx_valid(tx_valid),
		.tx_nib(tx_nib));
	// Line monitor: a level change is a one, groups framed by the start pair
	always @(negedge clk) if (line_bit_strobe) begin
		sh = {sh[8:0], {line_pos, line_neg} != lvl};
		lvl = {line_pos, line_neg};
		zrun = sh[0] ? 0 : zrun + 1;
		if (zrun > zmax) zmax = zrun;
		if (bits >= 0) bits++;
		if (bits > 0 && bits % 5 == 0) syms.push_back(sh[4:0]);
		if (bits < 0 && sh == 10'h311) bits = 0;
	end
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Whole frame with every data nibble and a trailing errored nibble
	task automatic tx_frame;
		u_fec_mac_model.send(6'h25);
		u_fec_mac_model.send(6'h25);
		for (int i = 0; i < 16; i++) u_fec_mac_model.send({2'b10, i[3:0]});
		u_fec_mac_model.send(6'h30);
		u_fec_mac_model.idle(300);
		check(bits >= 0, 1);
		for (int i = 0; i < 16; i++) check(syms[i], code[i]);
		check(syms[16], SYM_HALT);
		check(syms[17], SYM_ESD1);
		check(syms[18], SYM_ESD2);
		check(syms[19], SYM_IDLE);
		check(u_fec_mac_model.stalls > 0, 1);
	endtask
	// Low-power idle leaves the line still for whole groups
	task automatic tx_lpi;
		zmax = 0;
		repeat (3) u_fec_mac_model.send(6'h11);
		u_fec_mac_model.idle(100);
		check(zmax >= 10, 1);
	endtask
	// Idle must look random only while scrambling
	task automatic tx_scramble;
		scr_bypass = 1'b0;
		u_fec_mac_model.idle(20);
		zmax = 0;
		u_fec_mac_model.idle(200);
		check(zmax > 1, 1);
		scr_bypass = 1'b1;
		u_fec_mac_model.idle(20);
		zmax = 0;
		u_fec_mac_model.idle(200);
		check(zmax, 0);
	endtask
	task automatic rx_put(input logic [4:0] s, input logic chk, input logic [5:0] exp);
		rx_sym_valid = 1'b1;
		rx_sym = s;
		@(posedge clk);
		#1 rx_sym_valid = 1'b0;
		rx_sym = ~s;
		if (chk) check({rx_strobe, rx_dv, rx_er, rxd}, {1'b1, exp});
		@(posedge clk);
		#1;
	endtask
	// Receive frame, bad codes inside it, then framing faults
	task automatic rx_frame;
		rx_put(SYM_SSD1, 0, 0);
		rx_put(SYM_SSD2, 1, 6'h25);
		for (int i = 0; i < 16; i++) rx_put(code[i], 1, {2'b10, i[3:0]});
		foreach (junk[i]) rx_put(junk[i], 1, 6'h30);
		rx_put(SYM_ESD1, 1, 6'h00);
		rx_put(SYM_ESD2, 1, 6'h00);
		rx_put(SYM_IDLE, 0, 0);
		rx_put(SYM_LPI, 1, 6'h11);
		rx_put(SYM_SSD1, 0, 0);
		rx_put(SYM_ESD1, 0, 0);
		check(rx_er, 1);
	endtask
	// Main sequence
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		scr_bypass = 1'b1;
		rx_sym_valid = 1'b0;
		rx_sym = 5'h00;
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		tx_frame();
		tx_lpi();
		tx_scramble();
		rx_frame();
		wrap_up();
	end
	// Watchdog well past the expected run time
	initial begin
		#40000;
		num_errors++;
		wrap_up();
	end
endmodule
